/* File: bench/sxd_far_end.sv */
// Far-end transceiver model: echoes the serial stream and counts line edges.
`timescale 1ns/1ps
`default_nettype none
module sxd_far_end #(
  parameter int DELAY = 1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Serial line
  input  wire logic tx_serial,
  output logic      rx_serial,
  // Detection
  output logic [15:0] band_edges
);
  logic [7:0] pipe;
  logic       last;

  // ----------------------------------------------------------------
  // Line echo and edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe       <= 8'h00;
      last       <= 1'b0;
      band_edges <= 16'h0000;
    end else begin
      pipe <= {pipe[6:0], tx_serial};
      last <= tx_serial;
      if (tx_serial != last) begin
        band_edges <= band_edges + 16'h0001;
      end
    end
  end

  assign rx_serial = pipe[DELAY-1];
endmodule : sxd_far_end
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench of the serial channel datapath.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         core_clk;
  logic         arst_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [159:0] tx_data;
  logic         tx_valid;
  logic         tx_ready;
  logic         tx_div;
  logic [159:0] rx_data;
  logic         rx_valid;
  logic         rx_wclk;
  logic         rx_locked;
  logic         tx_serial;
  logic         rx_serial;
  logic         band_act;
  logic         low_pwr;
  logic [15:0]  band_edges;
  logic [159:0] got_q[$];
  logic [159:0] exp_q[$];
  logic         saw_div;
  int           error_cnt;
  int           n_compared;
  int           wid[8] = '{16, 20, 32, 40, 64, 80, 128, 160};

  sxd_top #(.HIGH_RATE(1'b1)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_divided_clock_out(tx_div), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_user_word_clock(rx_wclk), .rx_locked(rx_locked),
    .tx_serial(tx_serial), .rx_serial(rx_serial), .tx_band_active(band_act),
    .receiver_low_power_mode(low_pwr)
  );

  sxd_far_end #(.DELAY(1)) far_u (
    .core_clk(core_clk), .arst_n(arst_n), .tx_serial(tx_serial),
    .rx_serial(rx_serial), .band_edges(band_edges)
  );

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Receive capture on the user side
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      got_q.push_back(rx_data);
      chk(rx_wclk, 1'b1);
    end
    if (tx_div === 1'b1) begin
      saw_div = 1'b1;
    end
  end

  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic quit;
    error_cnt++;
    end_sim();
  endtask : quit

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) begin
        break;
      end
    end
    if (i == 50) begin
      quit();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd

  task automatic push(input logic [159:0] w);
    int i;
    @(posedge core_clk);
    tx_data  <= w;
    tx_valid <= 1'b1;
    for (i = 0; i < 500; i++) begin
      @(posedge core_clk);
      if (tx_ready === 1'b1) begin
        break;
      end
    end
    if (i == 500) begin
      quit();
    end
    tx_valid <= 1'b0;
  endtask : push

  // Queue n words in the FIFO with the channel halted, or send them through the bypass.
  task automatic stream(input int code, input int enc, input int n, input bit byp);
    logic [159:0] w;
    logic [31:0]  cfg;
    int           k;
    cfg = (byp ? 32'h0 : 32'h20) | code | (enc << 3);
    wr(8'h00, cfg);
    got_q.delete();
    exp_q.delete();
    saw_div = 1'b0;
    if (byp) begin
      wr(8'h00, cfg | 32'hC0);
    end
    for (k = 0; k < n; k++) begin
      w = ({5{32'h9E3779B9 * (k + code + 3)}} & ((160'h1 << wid[code]) - 160'h1)) | 160'h1;
      push(w);
      exp_q.push_back(w);
    end
    if (n == 16) begin
      @(posedge core_clk);
      #1;
      chk(tx_ready, 1'b0);
      rd(8'h0C, 32'h100);
    end
    if (!byp) begin
      wr(8'h00, cfg | 32'hC0);
    end
    for (k = 0; k < 400 * n + 400 && got_q.size() < n; k++) begin
      @(posedge core_clk);
    end
    if (got_q.size() < n) begin
      quit();
    end
    for (k = 0; k < n; k++) begin
      chk(got_q[k], exp_q[k]);
    end
    chk(rx_locked, 1'b1);
    chk(saw_div, 1'b1);
  endtask : stream

  initial begin
    logic [31:0] q;
    logic        e;
    logic [15:0] n0;
    core_clk = 1'b0;
    arst_n   = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    tx_data  = 160'h0;
    tx_valid = 1'b0;
    saw_div  = 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'h00, 32'h21);
    rd(8'h04, 32'h19);
    rd(8'h08, 32'h19);
    apb(1'b1, 8'h10, 32'hFF, q, e);
    chk(e, 1'b1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk(q, 32'h0);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h19);
    wr(8'h04, 32'h1A);
    rd(8'h04, 32'h19);
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h4);
    rd(8'h08, 32'h19);
    wr(8'h04, 32'h19);
    wr(8'h00, 32'h221);
    @(posedge core_clk);
    chk(low_pwr, 1'b1);
    n0 = band_edges;
    wr(8'h00, 32'h121);
    repeat (160) @(posedge core_clk);
    chk(band_act, 1'b1);
    chk(band_edges - n0 >= 16'h4, 1'b1);
    rd(8'h0C, 32'h1);
    wr(8'h00, 32'h001);
    repeat (2) @(posedge core_clk);
    chk(band_act, 1'b0);
    @(posedge core_clk);
    tx_valid <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk(tx_ready, 1'b0);
    tx_valid <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      stream(c, 0, 2, 1'b0);
    end
    for (int en = 1; en < 4; en++) begin
      stream(4, en, 2, 1'b0);
    end
    stream(5, 3, 2, 1'b1);
    stream(0, 0, 16, 1'b0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire

/* File: rtl/sxd_defs.svh */
// Register map, field positions, reset values and timing constants of the serial datapath.
`ifndef SXD_DEFS_SVH
`define SXD_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SXD_CTRL        8'h00
`define SXD_TXMUL       8'h04
`define SXD_RXMUL       8'h08
`define SXD_STAT        8'h0C
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define SXD_F_WSEL      2:0
`define SXD_F_ENC       4:3
`define SXD_F_FIFO      5
`define SXD_F_TXEN      6
`define SXD_F_RXEN      7
`define SXD_F_BAND      8
`define SXD_F_LOWPWR    9
`define SXD_F_HDRERR    2
`define SXD_CTRL_RST    10'h021
`define SXD_MUL_RST     5'h19
// ----------------------------------------------------------------
// Multiplier, rate generator and signalling constants
// ----------------------------------------------------------------
`define SXD_MUL_MIN     5'h04
`define SXD_MUL_MAX     5'h19
`define SXD_NCO_MOD     6'h19
`define SXD_NCO_MID     6'h0C
`define SXD_BAND_BITS   8'h10
`define SXD_FMAX        8'hC8
`define SXD_H66         2'h2
`define SXD_H67         3'h2
// ----------------------------------------------------------------
// Word widths per selection code
// ----------------------------------------------------------------
`define SXD_W0          8'h10
`define SXD_W1          8'h14
`define SXD_W2          8'h20
`define SXD_W3          8'h28
`define SXD_W4          8'h40
`define SXD_W5          8'h50
`define SXD_W6          8'h80
`define SXD_W7          8'hA0
`endif

/* File: rtl/sxd_pkg.sv */
// Types shared by the serial datapath.
package sxd_pkg;
  typedef enum logic [1:0] {
    ENC_NONE = 2'h0, ENC_8B10B = 2'h1, ENC_64B66B = 2'h2, ENC_64B67B = 2'h3
  } sxd_enc_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_BAND = 3'b100
  } sxd_tx_st_t;
  typedef enum logic [2:0] {
    RX_OFF = 3'b001, RX_HUNT = 3'b010, RX_RUN = 3'b100
  } sxd_rx_st_t;
endpackage : sxd_pkg

/* File: rtl/sxd_top.sv */
// Serial transceiver channel datapath with APB registers and transmit FIFO.
// Notes on behaviour
// RULE_01: Transmit serializes words of 16, 20, 32, 40, 64, 80, or 128/160 bits.
// RULE_02: Receive deserializes into words of the same selectable widths.
// RULE_03: Bit clock is reference rate times a programmable factor 4 to 25.
// RULE_04: A divided transmit clock at word rate is exported for user logic.
// RULE_05: Transmit data passes a FIFO that configuration enables or bypasses.
// RULE_06: Transmit optionally applies one line encoding: 8B/10B, 64B/66B or 64B/67B.
// RULE_07: Receive optionally decodes the same configured line encoding.
// RULE_08: Receiver recovers timing from the data transitions, no forwarded clock.
// RULE_09: Received words are handed over on the user receive word clock.
// RULE_10: Idle transmitter can send slow out-of-band signalling the far end detects.
// RULE_11: Transmitter and receiver run independent multipliers and configuration; the code shares word width and encoding between them.
// RULE_12: Channel settings have reset defaults and may change during operation.
// RULE_13: Channels come in groups of four, each with transmitter and receiver. This module implements a single channel.
// RULE_14: With no encoding selected, words pass unchanged.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sxd_defs.svh"

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module sxd_fifo #(
  parameter int W = 160,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   next_level;
  logic          push, pop;
  assign in_ready  = (level != D[AW:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_comb begin
    next_wp    = push ? wp + 1'b1 : wp;
    next_rp    = pop ? rp + 1'b1 : rp;
    next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp    <= '0;
      rp    <= '0;
      level <= '0;
    end else begin
      wp    <= next_wp;
      rp    <= next_rp;
      level <= next_level;
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule : sxd_fifo

// ----------------------------------------------------------------
// Channel datapath
// ----------------------------------------------------------------
module sxd_top import sxd_pkg::*; #(
  parameter bit HIGH_RATE = 1'b1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Transmit user side
  input  wire logic [159:0] tx_data,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  output logic              tx_divided_clock_out,
  // Receive user side
  output logic [159:0]      rx_data,
  output logic              rx_valid,
  output logic              rx_user_word_clock,
  output logic              rx_locked,
  // Serial line and mode outputs
  output logic              tx_serial,
  input  wire logic         rx_serial,
  output logic              tx_band_active,
  output logic              receiver_low_power_mode
);
  logic [9:0]   ctrl, next_ctrl;
  logic [4:0]   txm, next_txm, rxm, next_rxm;
  logic         hdr_err, next_hdr_err;
  logic [31:0]  next_prdata;
  logic         hit, wr, rx_bad;
  logic [4:0]   f_level;
  logic [159:0] f_data, src_data;
  logic         f_in_ready, f_valid, src_valid, load;
  logic [7:0]   wlen, flen;
  sxd_enc_t     enc;
  logic [2:0]   wsel;
  logic [159:0] wmask;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign hit     = paddr inside {`SXD_CTRL, `SXD_TXMUL, `SXD_RXMUL, `SXD_STAT};
  assign wr      = psel & penable & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign enc     = sxd_enc_t'(ctrl[`SXD_F_ENC]);
  assign receiver_low_power_mode = ctrl[`SXD_F_LOWPWR];
  always_comb begin
    next_ctrl    = ctrl;
    next_txm     = txm;
    next_rxm     = rxm;
    next_hdr_err = hdr_err;
    next_prdata  = prdata;
    if (wr) begin
      case (paddr)
        `SXD_CTRL:  next_ctrl = pwdata[9:0]; // [RULE_12]
        `SXD_TXMUL: if (pwdata[4:0] >= `SXD_MUL_MIN && pwdata[4:0] <= `SXD_MUL_MAX) begin
          next_txm = pwdata[4:0]; // [RULE_03] [RULE_11]
        end
        `SXD_RXMUL: if (pwdata[4:0] >= `SXD_MUL_MIN && pwdata[4:0] <= `SXD_MUL_MAX) begin
          next_rxm = pwdata[4:0]; // [RULE_03] [RULE_11]
        end
        `SXD_STAT:  if (pwdata[`SXD_F_HDRERR]) begin
          next_hdr_err = 1'b0;
        end
        default:    next_ctrl = ctrl;
      endcase
    end
    if (rx_bad) begin
      next_hdr_err = 1'b1;
    end
    if (psel & ~penable) begin
      case (paddr)
        `SXD_CTRL:  next_prdata = {22'h0, ctrl};
        `SXD_TXMUL: next_prdata = {27'h0, txm};
        `SXD_RXMUL: next_prdata = {27'h0, rxm};
        `SXD_STAT:  next_prdata = {23'h0, f_level, 1'b0, hdr_err, rx_locked, tx_band_active};
        default:    next_prdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl    <= `SXD_CTRL_RST;
      txm     <= `SXD_MUL_RST;
      rxm     <= `SXD_MUL_RST;
      hdr_err <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      ctrl    <= next_ctrl;
      txm     <= next_txm;
      rxm     <= next_rxm;
      hdr_err <= next_hdr_err;
      prdata  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Word and frame lengths
  // ----------------------------------------------------------------
  assign wsel = (!HIGH_RATE && ctrl[2]) ? 3'h5 : ctrl[`SXD_F_WSEL];
  always_comb begin
    case (wsel)
      3'h0:    wlen = `SXD_W0; // [RULE_01] [RULE_02]
      3'h1:    wlen = `SXD_W1;
      3'h2:    wlen = `SXD_W2;
      3'h3:    wlen = `SXD_W3;
      3'h4:    wlen = `SXD_W4;
      3'h5:    wlen = `SXD_W5;
      3'h6:    wlen = `SXD_W6;
      default: wlen = `SXD_W7;
    endcase
    case (enc)
      ENC_8B10B:  flen = wlen + (wlen >> 2);
      ENC_64B66B: flen = wlen + 8'h02;
      ENC_64B67B: flen = wlen + 8'h03;
      default:    flen = wlen; // [RULE_14]
    endcase
  end
  assign wmask = {160{1'b1}} >> (8'hA0 - wlen);

  // ----------------------------------------------------------------
  // Transmit FIFO or bypass
  // ----------------------------------------------------------------
  sxd_fifo #(.W(160), .D(16)) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid & ctrl[`SXD_F_FIFO]),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (load & ctrl[`SXD_F_FIFO]),
    .level     (f_level)
  );
  assign src_data  = ctrl[`SXD_F_FIFO] ? f_data : tx_data;      // [RULE_05]
  assign src_valid = ctrl[`SXD_F_FIFO] ? f_valid : tx_valid;
  assign tx_ready  = ctrl[`SXD_F_FIFO] ? f_in_ready : load;     // [RULE_05]

  // ----------------------------------------------------------------
  // Encoder and decoder per byte
  // ----------------------------------------------------------------
  logic [199:0] enc8, tfrm, rsh, next_rsh, rfrm;
  logic [159:0] dec8, rword;
  logic [19:0]  bad8;
  for (genvar b = 0; b < 20; b++) begin : g_byte
    assign enc8[b*10 +: 10] = {src_data[b*8+7], ~src_data[b*8+7], src_data[b*8 +: 8]};
    assign dec8[b*8 +: 8]   = rfrm[b*10 +: 8];
    assign bad8[b] = (b < (wlen >> 3)) && (rfrm[b*10+8] == rfrm[b*10+9]);
  end
  always_comb begin
    case (enc)
      ENC_8B10B:  tfrm = enc8; // [RULE_06]
      ENC_64B66B: tfrm = {38'h0, src_data & wmask, `SXD_H66};
      ENC_64B67B: tfrm = {37'h0, src_data & wmask, `SXD_H67};
      default:    tfrm = {40'h0, src_data & wmask}; // [RULE_14]
    endcase
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  sxd_tx_st_t   tx_st, next_tx_st;                                // [RULE_13]
  logic [5:0]   tacc, next_tacc;
  logic         tbit;
  logic [199:0] tsh, next_tsh;
  logic [7:0]   tcnt, next_tcnt, bcnt, next_bcnt;
  logic         next_ser, next_tclk;
  assign tbit = (tacc + {1'b0, txm}) >= `SXD_NCO_MOD;           // [RULE_03]
  assign load = tbit & ctrl[`SXD_F_TXEN] & src_valid & (tx_st != TX_SEND || tcnt == flen);
  assign tx_band_active = (tx_st == TX_BAND);
  always_comb begin
    next_tacc  = tacc + {1'b0, txm} - (tbit ? `SXD_NCO_MOD : 6'h0);
    next_tx_st = tx_st;
    next_tsh   = tsh;
    next_tcnt  = tcnt;
    next_bcnt  = bcnt;
    next_ser   = tx_serial;
    if (load) begin
      next_tx_st = TX_SEND;
      next_ser   = tfrm[0];                                        // [RULE_01]
      next_tsh   = tfrm >> 1;
      next_tcnt  = 8'h01;
    end else if (tbit) begin
      case (tx_st)
        TX_SEND: if (tcnt < flen) begin
          next_ser  = tsh[0];
          next_tsh  = tsh >> 1;
          next_tcnt = tcnt + 8'h01;
        end else begin
          next_tx_st = TX_IDLE;
          next_ser   = 1'b0;
        end
        TX_BAND: begin
          next_bcnt = bcnt + 8'h01;
          if (bcnt == `SXD_BAND_BITS - 8'h01) begin
            next_bcnt = 8'h0;
            next_ser  = ~tx_serial;                                // [RULE_10]
          end
          if (ctrl[`SXD_F_TXEN] || !ctrl[`SXD_F_BAND]) begin
            next_tx_st = TX_IDLE;
            next_ser   = 1'b0;
          end
        end
        TX_IDLE: if (!ctrl[`SXD_F_TXEN] && ctrl[`SXD_F_BAND]) begin
          next_tx_st = TX_BAND;                                    // [RULE_10]
          next_bcnt  = 8'h0;
        end
        default: next_tx_st = TX_IDLE;
      endcase
    end
    next_tclk = (next_tx_st == TX_SEND) && (next_tcnt <= (flen >> 1)); // [RULE_04]
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st     <= TX_IDLE;
      tacc      <= 6'h0;
      tsh       <= '0;
      tcnt      <= 8'h0;
      bcnt      <= 8'h0;
      tx_serial <= 1'b0;
      tx_divided_clock_out <= 1'b0;
    end else begin
      tx_st     <= next_tx_st;
      tacc      <= next_tacc;
      tsh       <= next_tsh;
      tcnt      <= next_tcnt;
      bcnt      <= next_bcnt;
      tx_serial <= next_ser;
      tx_divided_clock_out <= next_tclk;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  sxd_rx_st_t   rx_st, next_rx_st;
  logic [5:0]   racc, next_racc;
  logic         rbit, rprev, edge_seen, hdr_ok, rx_done;
  logic [7:0]   rcnt, next_rcnt;
  logic         next_lock, next_rvalid, next_rclk;
  logic [159:0] next_rdata;
  assign rbit      = (racc + {1'b0, rxm}) >= `SXD_NCO_MOD;
  assign edge_seen = rx_serial != rprev;
  assign next_rsh  = {rx_serial, rsh[199:1]};
  assign rfrm      = next_rsh >> (`SXD_FMAX - flen);
  assign rx_done   = (rx_st == RX_RUN) && rbit && (rcnt + 8'h01 >= flen);
  always_comb begin
    case (enc)
      ENC_8B10B:  begin hdr_ok = (bad8 == '0); rword = dec8; end        // [RULE_07]
      ENC_64B66B: begin hdr_ok = rfrm[1:0] == `SXD_H66; rword = rfrm[161:2]; end
      ENC_64B67B: begin hdr_ok = rfrm[2:0] == `SXD_H67; rword = rfrm[162:3]; end
      default:    begin hdr_ok = 1'b1; rword = rfrm[159:0]; end       // [RULE_14]
    endcase
  end
  assign rx_bad = rx_done & ~hdr_ok;
  always_comb begin
    next_racc   = racc + {1'b0, rxm} - (rbit ? `SXD_NCO_MOD : 6'h0);
    next_rx_st  = rx_st;
    next_rcnt   = rcnt;
    next_lock   = rx_locked;
    next_rvalid = 1'b0;
    next_rdata  = rx_data;
    if (edge_seen) begin
      next_racc = `SXD_NCO_MID;                                    // [RULE_08]
    end
    case (rx_st)
      RX_OFF:  if (ctrl[`SXD_F_RXEN]) begin
        next_rx_st = RX_HUNT;
      end
      RX_HUNT: if (edge_seen) begin
        next_rx_st = RX_RUN;                                       // [RULE_08]
        next_rcnt  = {7'h0, rbit};
        // A header opens with a zero, so its first transition marks the second bit.
        if (enc == ENC_64B66B || enc == ENC_64B67B) begin
          next_rcnt = next_rcnt + 8'h01;                           // [RULE_07]
        end
      end
      RX_RUN:  if (rx_done) begin
        if (hdr_ok) begin
          next_rcnt   = 8'h0;
          next_lock   = 1'b1;
          next_rvalid = 1'b1;
          next_rdata  = rword & wmask;                             // [RULE_02]
        end else begin
          next_lock = 1'b0;
        end
      end else if (rbit) begin
        next_rcnt = rcnt + 8'h01;
      end
      default: next_rx_st = RX_OFF;
    endcase
    if (!ctrl[`SXD_F_RXEN]) begin
      next_rx_st = RX_OFF;
      next_lock  = 1'b0;
    end
    next_rclk = next_rvalid | (rx_user_word_clock & (next_rcnt < (flen >> 1))); // [RULE_09]
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st     <= RX_OFF;
      racc      <= 6'h0;
      rprev     <= 1'b0;
      rsh       <= '0;
      rcnt      <= 8'h0;
      rx_locked <= 1'b0;
      rx_valid  <= 1'b0;
      rx_data   <= '0;
      rx_user_word_clock <= 1'b0;
    end else begin
      rx_st     <= next_rx_st;
      racc      <= next_racc;
      rprev     <= rx_serial;
      rsh       <= rbit ? next_rsh : rsh;
      rcnt      <= next_rcnt;
      rx_locked <= next_lock;
      rx_valid  <= next_rvalid;
      rx_data   <= next_rdata;
      rx_user_word_clock <= next_rclk;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  tx_mult_range_a: assert property (txm >= `SXD_MUL_MIN && txm <= `SXD_MUL_MAX) // [RULE_03]
    else $error("transmit multiplier out of range");
  rx_mult_range_a: assert property (rxm >= `SXD_MUL_MIN && rxm <= `SXD_MUL_MAX) // [RULE_11]
    else $error("receive multiplier out of range");
  bypass_load_a: assert property (!ctrl[`SXD_F_FIFO] && tx_valid && tx_ready |=> tx_st == TX_SEND) // [RULE_05]
    else $error("bypassed word not sent");
  band_idle_a: assert property (ctrl[`SXD_F_TXEN] && tbit |=> tx_st != TX_BAND) // [RULE_10]
    else $error("out-of-band while transmitter enabled");
  tx_count_a: assert property (tx_st == TX_SEND |-> tcnt <= flen) // [RULE_01]
    else $error("frame bit count overrun");
  rx_lock_a: assert property (rx_valid |-> rx_locked && rx_user_word_clock) // [RULE_09]
    else $error("word delivered without lock");
  rx_width_a: assert property (rx_valid |-> (rx_data & ~wmask) == '0) // [RULE_02]
    else $error("received word wider than selection");
  rx_hunt_a: assert property (rx_st == RX_HUNT && edge_seen && ctrl[`SXD_F_RXEN] |=> rx_st == RX_RUN) // [RULE_08]
    else $error("receiver missed first transition");
  tx_serial_a: assert property (load && (enc == ENC_64B66B || enc == ENC_64B67B) |=> !tx_serial) // [RULE_06]
    else $error("frame header start bit not zero");
endmodule : sxd_top
`default_nettype wire
